// File: rtl/exc_unit.sv
// exception arbiter, escalation, nesting and wake logic of the core
`timescale 1ns/100ps
`include "exc_cfg_regs.svh"

module exc_unit #(
    parameter int NUM_IRQ    = 17,
    parameter int PRI_W      = 3,
    parameter int WAKE_LINES = 20,
    parameter int NUM_BP     = 2
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    input  wire logic [NUM_IRQ-1:0]      irq,
    input  wire logic                    nmi,
    input  wire logic                    primask,
    input  wire exc_pkg::hnd_en_s        hnd_en,
    input  wire logic                    mem_illegal,
    input  wire logic                    bus_prefetch_err,
    input  wire logic                    bus_data_err,
    input  wire logic                    ecc_uncorr,
    input  wire logic                    usage_undef,
    input  wire logic                    usage_bad_state,
    input  wire logic                    svc_exec,
    input  wire logic                    dbg_ext,
    input  wire logic [NUM_BP-1:0]       bp_en,
    input  wire logic [NUM_BP-1:0]       bp_hit,
    input  wire logic                    wp_en,
    input  wire logic                    wp_hit,
    input  wire logic                    pendsrv_set,
    input  wire logic                    tick,
    input  wire exc_pkg::prio_wr_s       prio_wr,
    input  wire logic                    stack_done,
    input  wire logic                    unstack_done,
    input  wire logic                    exc_exit,
    input  wire logic                    sleep_req,
    input  wire exc_pkg::acc_s           acc,
    output logic [5:0]                   exc_vector,
    output logic                         stack_push,
    output logic                         tail_chain,
    output logic                         unstack_req,
    output logic                         wake,
    output logic [WAKE_LINES-1:0]        wake_line_count,
    output exc_pkg::bb_s                 bb,
    output logic                         swd_only
);
    import exc_pkg::*;

    core_s               s;
    core_s               next_s;
    logic                dbg_evt;
    logic                mem_evt;
    logic                bus_evt;
    logic                usage_evt;
    logic [`NUM_VEC-1:0] cand;
    logic [5:0]          best_idx;
    logic [3:0]          best_pri;
    logic [3:0]          top_pri;

    // --------------------------------------------------------------
    // event sources
    // --------------------------------------------------------------
    // only the two comparators and one watchpoint exist
    assign dbg_evt   = dbg_ext | (|(bp_hit & bp_en))
                     | (wp_hit & wp_en);
    assign mem_evt   = mem_illegal;
    assign bus_evt   = bus_prefetch_err | bus_data_err
                     | ecc_uncorr;
    assign usage_evt = usage_undef | usage_bad_state;
    assign cand      = s.pend | {irq, 16'h0000};

    function automatic logic is_rsvd(input logic [5:0] v);
        is_rsvd = (v == 6'h02) || (v >= 6'h07 && v <= 6'h0a)
               || (v == 6'h0d);
    endfunction

    // --------------------------------------------------------------
    // arbitration
    // --------------------------------------------------------------
    // slot 2 carries the nmi internally; it is delivered on vector 3
    always_comb
    begin
        logic [3:0] p;
        p        = `PRI_THREAD;
        best_idx = `VEC_THREAD;
        best_pri = `PRI_THREAD;
        for (int i = 2; i < `NUM_VEC; i++)
        begin
            if (i == 2)
                p = `PRI_NMI;
            else if (i == 3)
                p = `PRI_HARD;
            else
                p = {1'b0, s.prio[i]} + `PRI_PROG0;
            // strict compare keeps the lower vector on a tie
            if (cand[i] && !(primask && i > 3)
                && p < best_pri)
            begin
                best_idx = 6'(i);
                best_pri = p;
            end
        end
    end

    assign top_pri = (s.depth == 4'h0) ? `PRI_THREAD
                   : s.stk_pri[s.depth - 4'h1];

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb
    begin
        next_s         = s;
        next_s.entry   = 1'b0;
        next_s.tail    = 1'b0;
        next_s.unstack = 1'b0;
        next_s.wake    = 1'b0;

        if (prio_wr.wr && prio_wr.vec > `VEC_HARD
            && prio_wr.vec < 6'(`NUM_VEC) && !is_rsvd(prio_wr.vec))
            next_s.prio[prio_wr.vec] = prio_wr.val;

        if (sleep_req)
            next_s.sleeping = 1'b1;

        case (s.st)
            ST_IDLE, ST_ACTIVE:
            begin
                if (s.st == ST_ACTIVE && exc_exit)
                begin
                    if (s.cur_idx == `VEC_RESET)
                    begin
                        // reset handler owns no frame
                        next_s.st      = ST_IDLE;
                        next_s.cur_idx = `VEC_THREAD;
                        next_s.cur_pri = `PRI_THREAD;
                    end
                    else if (best_pri < top_pri)
                    begin
                        next_s.cur_idx        = best_idx;
                        next_s.cur_pri        = best_pri;
                        next_s.pend[best_idx] = 1'b0;
                        next_s.tail           = 1'b1;
                    end
                    else
                    begin
                        next_s.st      = ST_UNSTACK;
                        next_s.unstack = 1'b1;
                    end
                end
                else if (best_pri < s.cur_pri
                         && s.depth < 4'(`NEST_DEPTH))
                begin
                    if (s.sleeping)
                    begin
                        next_s.wake     = 1'b1;
                        next_s.sleeping = 1'b0;
                    end
                    next_s.stk_idx[s.depth] = s.cur_idx;
                    next_s.stk_pri[s.depth] = s.cur_pri;
                    next_s.depth   = s.depth + 4'h1;
                    next_s.st      = ST_STACK;
                    next_s.cur_idx = best_idx;
                    next_s.cur_pri = best_pri;
                    next_s.entry   = 1'b1;
                end
            end
            ST_STACK:
            begin
                // a better request during stacking takes the frame
                if (best_pri < s.cur_pri)
                begin
                    next_s.cur_idx = best_idx;
                    next_s.cur_pri = best_pri;
                end
                if (stack_done)
                begin
                    next_s.st                     = ST_ACTIVE;
                    next_s.pend[next_s.cur_idx]   = 1'b0;
                end
            end
            ST_UNSTACK:
            begin
                if (unstack_done)
                begin
                    next_s.depth   = s.depth - 4'h1;
                    next_s.cur_idx = s.stk_idx[s.depth - 4'h1];
                    next_s.cur_pri = s.stk_pri[s.depth - 4'h1];
                    next_s.st      = (s.stk_idx[s.depth - 4'h1]
                                      == `VEC_THREAD) ? ST_IDLE
                                                      : ST_ACTIVE;
                end
            end
            default:
                next_s.st = ST_IDLE;
        endcase

        // setting after clearing: a new event is never lost
        if (nmi)
            next_s.pend[`VEC_NMI_SLOT] = 1'b1;
        if (mem_evt)
            next_s.pend[hnd_en.mem ? `VEC_MEM : `VEC_HARD] = 1'b1;
        if (bus_evt)
            next_s.pend[hnd_en.bus ? `VEC_BUS : `VEC_HARD] = 1'b1;
        if (usage_evt)
            next_s.pend[hnd_en.usage ? `VEC_USAGE : `VEC_HARD] = 1'b1;
        if (svc_exec)
            next_s.pend[`VEC_SVC] = 1'b1;
        if (dbg_evt)
            next_s.pend[`VEC_DBG] = 1'b1;
        if (pendsrv_set)
            next_s.pend[`VEC_PENDSRV] = 1'b1;
        if (tick)
            next_s.pend[`VEC_TICK] = 1'b1;

        next_s.vec_o = (next_s.cur_idx == `VEC_NMI_SLOT) ? `VEC_HARD
                     : next_s.cur_idx;
        next_s.wakeup_irq_ctrl   = {irq, dbg_evt, tick, nmi};
        next_s.swd_only = 1'b1;

        // bit-band alias regions map one word per bit
        next_s.bb.hit   = acc.valid && (acc.addr[31:25] == 7'h11
                          || acc.addr[31:25] == 7'h21);
        next_s.bb.addr  = {acc.addr[31:28], 8'h00, acc.addr[24:7], 2'b00};
        next_s.bb.bit_n = {acc.addr[6:5], acc.addr[4:2]};
        next_s.bb.split = acc.valid
            && ((acc.size == 2'h1 && acc.addr[1:0] == 2'h3)
             || (acc.size == 2'h2 && acc.addr[1:0] != 2'h0));
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s          <= '0;
            s.st       <= ST_ACTIVE;
            s.cur_idx  <= `VEC_RESET;
            s.cur_pri  <= `PRI_RESET;
            s.vec_o    <= `VEC_RESET;
            s.prio     <= {`NUM_VEC{`PRIO_RST}};
            s.swd_only <= 1'b1;
        end
        else
            s <= next_s;
    end

    assign exc_vector  = s.vec_o;
    assign stack_push  = s.entry;
    assign tail_chain  = s.tail;
    assign unstack_req = s.unstack;
    assign wake        = s.wake;
    assign wake_line_count   = s.wakeup_irq_ctrl;
    assign bb          = s.bb;
    assign swd_only    = s.swd_only;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    a_reset_vector: assert property (@(posedge clk_sys)
        !rst_n |=> exc_vector == `VEC_RESET && s.cur_pri == 4'h0)
        else $error("reset not on vector 1");
    a_prio_default: assert property (@(posedge clk_sys)
        !rst_n |=> s.prio == '0)
        else $error("priorities not zero after reset");
    a_escalate_bus: assert property (@(posedge clk_sys)
        disable iff (!rst_n) bus_data_err && !hnd_en.bus |=> s.pend[3])
        else $error("bus fault not escalated");
    a_bus_pend: assert property (@(posedge clk_sys)
        disable iff (!rst_n) ecc_uncorr && hnd_en.bus |=> s.pend[5])
        else $error("bus fault not pended");
    a_usage_pend: assert property (@(posedge clk_sys)
        disable iff (!rst_n) usage_undef && hnd_en.usage |=> s.pend[6])
        else $error("usage fault not pended");
    a_svc_pend: assert property (@(posedge clk_sys)
        disable iff (!rst_n) svc_exec |=> s.pend[11])
        else $error("supervisor call not pended");
    a_nmi_taken: assert property (@(posedge clk_sys)
        disable iff (!rst_n) s.st == ST_IDLE && s.pend[2] && primask
        |=> stack_push && exc_vector == `VEC_HARD)
        else $error("nmi not taken at once");
    a_no_reserved: assert property (@(posedge clk_sys)
        disable iff (!rst_n) !is_rsvd(exc_vector))
        else $error("reserved vector active");
    a_tail_direct: assert property (@(posedge clk_sys)
        disable iff (!rst_n) tail_chain |-> !unstack_req
        ##1 !unstack_req && s.st == ST_ACTIVE)
        else $error("tail chain unstacked");
    a_wake_higher: assert property (@(posedge clk_sys)
        disable iff (!rst_n) wake |-> $past(s.sleeping)
        && s.cur_pri < $past(s.cur_pri))
        else $error("wake by lower priority");
endmodule

// File: shared/exc_cfg_regs.svh
// vector positions, priority codes and sizes of the exception unit
`ifndef EXC_CFG_REGS_SVH
`define EXC_CFG_REGS_SVH
`define VEC_THREAD   6'h00
`define VEC_RESET    6'h01
`define VEC_NMI_SLOT 6'h02
`define VEC_HARD     6'h03
`define VEC_MEM      6'h04
`define VEC_BUS      6'h05
`define VEC_USAGE    6'h06
`define VEC_SVC      6'h0b
`define VEC_DBG      6'h0c
`define VEC_PENDSRV  6'h0e
`define VEC_TICK     6'h0f
`define VEC_IRQ0     6'h10
`define NUM_VEC      33
`define NEST_DEPTH   12
`define PRI_RESET    4'h0
`define PRI_NMI      4'h1
`define PRI_HARD     4'h2
`define PRI_PROG0    4'h3
`define PRI_THREAD   4'hf
`define PRIO_RST     3'h0
`endif

// File: shared/exc_pkg.sv
// types shared by the exception unit
`include "exc_cfg_regs.svh"
package exc_pkg;
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_STACK   = 2'b01,
        ST_ACTIVE  = 2'b10,
        ST_UNSTACK = 2'b11
    } state_e;

    typedef struct packed {
        logic mem;
        logic bus;
        logic usage;
    } hnd_en_s;

    typedef struct packed {
        logic       wr;
        logic [5:0] vec;
        logic [2:0] val;
    } prio_wr_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [1:0]  size;
    } acc_s;

    typedef struct packed {
        logic        hit;
        logic [31:0] addr;
        logic [4:0]  bit_n;
        logic        split;
    } bb_s;

    typedef struct packed {
        state_e                              st;
        logic [5:0]                          cur_idx;
        logic [3:0]                          cur_pri;
        logic [3:0]                          depth;
        logic [`NEST_DEPTH-1:0][5:0]         stk_idx;
        logic [`NEST_DEPTH-1:0][3:0]         stk_pri;
        logic [`NUM_VEC-1:0]                 pend;
        logic [`NUM_VEC-1:0][2:0]            prio;
        logic                                sleeping;
        logic [5:0]                          vec_o;
        logic                                entry;
        logic                                tail;
        logic                                unstack;
        logic                                wake;
        logic [19:0]                         wakeup_irq_ctrl;
        bb_s                                 bb;
        logic                                swd_only;
    } core_s;
endpackage

// File: sim/core_model.sv
// processor core stand-in: answers context push and pop requests
`timescale 1ns/100ps
module core_model (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic slow,
    input  wire logic stack_push,
    input  wire logic unstack_req,
    output logic      stack_done,
    output logic      unstack_done
);
    int cnt_s = 0;
    int cnt_u = 0;
    // slow mode leaves a wide stacking window so a late arrival can land in it
    always @(posedge clk_sys)
    begin
        stack_done <= (cnt_s == 1);
        unstack_done <= (cnt_u == 1);
        if (!rst_n)
        begin
            cnt_s <= 0;
            cnt_u <= 0;
        end
        else
        begin
            cnt_s <= stack_push ? (slow ? 6 : 2) : (cnt_s > 0 ? cnt_s - 1 : 0);
            cnt_u <= unstack_req ? 2 : (cnt_u > 0 ? cnt_u - 1 : 0);
        end
    end
endmodule

// File: sim/exc_unit_tb.sv
// self-checking bench of the exception unit with a reference arbiter
`timescale 1ns/100ps
module exc_unit_tb;
    import exc_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [16:0] irq = '0;
    logic [13:0] ev = '0;
    logic [2:0]  den = 3'h7;
    logic        primask = 1'b0, exc_exit = 1'b0, sleep_req = 1'b0, slow = 1'b0;
    hnd_en_s     hnd_en = 3'h7;
    prio_wr_s    prio_wr = '0;
    acc_s        acc = '0;
    logic        stack_done, unstack_done, stack_push, tail_chain, unstack_req, wake, swd_only;
    logic [5:0]  exc_vector;
    logic [19:0] wake_line_count;
    bb_s         bb;
    logic [31:0] seed = 32'h0001858b;
    int          n_mismatch = 0, n_tests = 0, n_push = 0, n_tail = 0, n_wake = 0, n_unst = 0;
    int          pri [33];
    int          q [$];
    int          a, b, e, t0;
    logic [2:0]  hset [3] = '{3'h7, 3'h2, 3'h5};
    logic [5:0]  evv [14] = '{6'h04, 6'h05, 6'h05, 6'h05, 6'h06, 6'h06, 6'h0b, 6'h0c,
                              6'h0e, 6'h0f, 6'h0c, 6'h0c, 6'h0c, 6'h03};
    exc_unit exc_unit_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .irq(irq), .nmi(ev[13]), .primask(primask),
        .hnd_en(hnd_en), .mem_illegal(ev[0]), .bus_prefetch_err(ev[1]), .bus_data_err(ev[2]),
        .ecc_uncorr(ev[3]), .usage_undef(ev[4]), .usage_bad_state(ev[5]), .svc_exec(ev[6]),
        .dbg_ext(ev[7]), .bp_en(den[1:0]), .bp_hit(ev[11:10]), .wp_en(den[2]), .wp_hit(ev[12]),
        .pendsrv_set(ev[8]), .tick(ev[9]), .prio_wr(prio_wr), .stack_done(stack_done),
        .unstack_done(unstack_done), .exc_exit(exc_exit), .sleep_req(sleep_req), .acc(acc),
        .exc_vector(exc_vector), .stack_push(stack_push), .tail_chain(tail_chain),
        .unstack_req(unstack_req), .wake(wake), .wake_line_count(wake_line_count), .bb(bb),
        .swd_only(swd_only));
    core_model core_model_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .stack_push(stack_push),
        .unstack_req(unstack_req), .stack_done(stack_done), .unstack_done(unstack_done));
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        n_push += (stack_push === 1'b1);
        n_tail += (tail_chain === 1'b1);
        n_wake += (wake === 1'b1);
        n_unst += (unstack_req === 1'b1);
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // reference arbiter: best priority, then lowest vector number
    function automatic int best();
        int r;
        r = q[0];
        foreach (q[i])
            if (pri[q[i]] < pri[r] || (pri[q[i]] == pri[r] && q[i] < r))
                r = q[i];
        return r;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic fire(input int k);
        @(negedge clk_sys);
        ev[k] = 1'b1;
        @(negedge clk_sys);
        ev = '0;
    endtask
    // waits for an entry; an irq level is withdrawn once its handler is entered
    task automatic wentry();
        int k;
        k = 0;
        while (stack_push !== 1'b1 && tail_chain !== 1'b1 && k < 20)
        begin
            cyc(1);
            k++;
        end
        chk(k < 20, 1);
        if (k < 20 && exc_vector >= 6'h10)
        begin
            @(negedge clk_sys);
            irq[exc_vector - 6'h10] = 1'b0;
        end
    endtask
    task automatic ret();
        cyc(10);
        @(negedge clk_sys);
        exc_exit = 1'b1;
        @(negedge clk_sys);
        exc_exit = 1'b0;
    endtask
    task automatic drain();
        // let a pop finish first: an exit is only legal while a handler is active
        for (int i = 0; i < 6; i++)
        begin
            cyc(6);
            if (exc_vector !== 6'h00)
                ret();
        end
        cyc(8);
        chk(exc_vector, 0);
    endtask
    task automatic setp(input int v, input int p);
        @(negedge clk_sys);
        prio_wr = '{1'b1, v[5:0], p[2:0]};
        @(negedge clk_sys);
        prio_wr = '0;
        pri[v] = p;
    endtask
    task automatic acct(input logic [31:0] ad, input logic [1:0] sz);
        @(negedge clk_sys);
        acc = '{1'b1, ad, sz};
        cyc(1);
        chk({bb.hit, bb.split}, {ad[31:25] == 7'h11 || ad[31:25] == 7'h21,
            (sz == 2'h2 && ad[1:0] != 2'h0) || (sz == 2'h1 && ad[1:0] == 2'h3)});
        if (bb.hit === 1'b1)
        begin
            chk(bb.addr, (ad & 32'hf0000000) | (((ad & 32'h01ffffff) >> 5) & 32'hfffffffc));
            chk(bb.bit_n, ((ad >> 5) & 32'h3) * 8 + ((ad >> 2) & 32'h7));
        end
        @(negedge clk_sys);
        acc = '0;
    endtask
    task conclude();
        $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #200us;
        n_mismatch++;
        conclude();
    end
    initial
    begin
        foreach (pri[i])
            pri[i] = 0;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        cyc(1);
        chk(exc_vector, 1);
        chk(swd_only, 1);
        @(negedge clk_sys);
        exc_exit = 1'b1;
        @(negedge clk_sys);
        exc_exit = 1'b0;
        cyc(3);
        chk({exc_vector, n_unst[3:0]}, 0);
        $display("done: reset");
        foreach (hset[h])
        begin
            @(negedge clk_sys);
            hnd_en = hset[h];
            for (int k = 0; k < 14; k++)
            begin
                fire(k);
                chk(wake_line_count[2:0], {k == 7 || k inside {[10:12]}, k == 9, k == 13});
                wentry();
                e = ((k == 0 && !hnd_en.mem) || (k inside {[1:3]} && !hnd_en.bus) ||
                     (k inside {[4:5]} && !hnd_en.usage)) ? 3 : evv[k];
                chk(exc_vector, e);
                drain();
            end
        end
        $display("done: events and escalation");
        @(negedge clk_sys);
        den = 3'h0;
        t0 = n_push;
        for (int k = 10; k < 13; k++)
            fire(k);
        cyc(4);
        chk(n_push - t0, 0);
        @(negedge clk_sys);
        den = 3'h7;
        for (int it = 0; it < 4; it++)
        begin
            a = rnd() % 17;
            b = (a + 1 + rnd() % 16) % 17;
            if (it > 0)
            begin
                setp(16 + a, rnd() % 8);
                setp(16 + b, rnd() % 8);
            end
            q = '{16 + a, 16 + b};
            @(negedge clk_sys);
            irq[a] = 1'b1;
            irq[b] = 1'b1;
            cyc(1);
            chk(wake_line_count[19:3], irq);
            wentry();
            e = best();
            chk(exc_vector, e);
            ret();
            t0 = n_tail;
            wentry();
            chk({8'(n_tail - t0), exc_vector}, {8'd1, 6'(e == q[0] ? q[1] : q[0])});
            drain();
        end
        $display("done: priorities and tail chaining");
        @(negedge clk_sys);
        primask = 1'b1;
        irq[0] = 1'b1;
        t0 = n_push;
        cyc(8);
        chk(n_push - t0, 0);
        fire(13);
        wentry();
        chk(exc_vector, 3);
        drain();
        @(negedge clk_sys);
        primask = 1'b0;
        wentry();
        chk(exc_vector, 16);
        drain();
        $display("done: masking");
        setp(21, 1);
        setp(16, 0);
        @(negedge clk_sys);
        irq[5] = 1'b1;
        wentry();
        cyc(10);
        @(negedge clk_sys);
        sleep_req = 1'b1;
        @(negedge clk_sys);
        sleep_req = 1'b0;
        t0 = n_wake;
        irq[0] = 1'b1;
        wentry();
        cyc(1);
        chk({8'(n_wake - t0), exc_vector}, {8'd1, 6'h10});
        drain();
        $display("done: wake");
        slow = 1'b1;
        fire(6);
        wentry();
        cyc(1);
        t0 = n_push;
        fire(13);
        cyc(3);
        chk({8'(n_push - t0), exc_vector}, {8'd0, 6'h03});
        drain();
        slow = 1'b0;
        $display("done: late arrival");
        acct(32'h22000084, 2'h2);
        acct(32'h20000001, 2'h2);
        acct(32'h42000012, 2'h1);
        acct(32'h40000003, 2'h0);
        acct(32'h40000003, 2'h1);
        $display("done: access decode");
        conclude();
    end
endmodule
